// file: verilog/led1_status_indicator.sv
// Notes on behaviour
// - force enable overrides all status conditions
// - force field: off, on, blink1, blink2
// - bit12 picks traffic override or blink-when-on
// - full duplex link lights steady
// - half duplex link lights steady
// - transmit activity blinks at mode two
// - receive activity blinks at mode two
// - transmit activity holds led on 10ms
// - receive activity holds led on 10ms
// - 100M link lights steady
// - 10M link lights steady
// - collision on link makes led blink
// - 100M link makes led blink
// - 10M link blinks; bit0 reserved read-only
// - blink field 3:0 sets mode three rate
// - one shared rate table for all modes
// - reverse bit swaps on and off shares
`include "led1_map.svh"
`default_nettype none

module led1_status_indicator #(
    parameter int MS_CYCLES = `LED_MS_CYCLES
) (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [31:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    input  wire logic [3:0]  pstrb_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic        link_up_in,
    input  wire logic        speed_100_in,
    input  wire logic        full_duplex_in,
    input  wire logic        tx_active_in,
    input  wire logic        rx_active_in,
    input  wire logic        collision_in,
    output logic             led_out
);

    // every check below runs on the block clock, quiet during reset
    default clocking cb_main @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // ----------------------------------------------------------------
    // register addresses
    // ----------------------------------------------------------------
    localparam logic [31:0] COMMON_ADDR = {14'h0000, `LED_COMMON_IDX, 2'b00};
    localparam logic [31:0] BLINK_ADDR  = {14'h0000, `LED_BLINK_IDX, 2'b00};
    localparam logic [31:0] CTRL_ADDR   = {14'h0000, `LED_CTRL_IDX, 2'b00};
    localparam logic [31:0] STATUS_ADDR = {14'h0000, `LED_STATUS_IDX, 2'b00};
    localparam int          TICK_W      = $clog2(MS_CYCLES + 1);
    localparam logic [4:0]  HOLD_LOAD   = 5'(`ACT_HOLD_MS + 1);

    led1_pkg::bus_state_t bus_state_reg;
    led1_pkg::bus_state_t bus_state_next;
    logic [15:0]       ctrl_reg;
    logic [15:0]       ctrl_next;
    logic [15:0]       blink_reg;
    logic [15:0]       blink_next;
    logic [15:0]       common_reg;
    logic [15:0]       common_next;
    logic [31:0]       prdata_reg;
    logic              pslverr_reg;
    logic              pready_reg;
    logic [TICK_W-1:0] tick_cnt_reg;
    logic              ms_tick_reg;
    logic [4:0]        tx_hold_reg;
    logic [4:0]        rx_hold_reg;
    logic              led_reg;
    logic              led_next;
    logic [2:0]        wave_w;

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    wire        hit_common = (paddr_in == COMMON_ADDR);
    wire        hit_blink  = (paddr_in == BLINK_ADDR);
    wire        hit_ctrl   = (paddr_in == CTRL_ADDR);
    wire        hit_status = (paddr_in == STATUS_ADDR);
    wire        mapped     = hit_common | hit_blink | hit_ctrl | hit_status;
    wire        access     = psel_in & penable_in;
    // a write lands only at the edge where pready is seen high
    wire        wr_commit  = access & pready_reg & pwrite_in & mapped;
    wire [15:0] lane_mask  = {{8{pstrb_in[1]}}, {8{pstrb_in[0]}}};

    // merge written lanes into a register, keeping read-only bits
    function automatic logic [15:0] merge(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [15:0] wmask);
        merge = (old_v & ~wmask) | (new_v & wmask);
    endfunction : merge

    assign ctrl_next   = (wr_commit & hit_ctrl)
                       ? merge(ctrl_reg, pwdata_in[15:0], lane_mask & `CTRL_WRITE_MASK)
                       : ctrl_reg;
    assign blink_next  = (wr_commit & hit_blink)
                       ? merge(blink_reg, pwdata_in[15:0], lane_mask)
                       : blink_reg;
    assign common_next = (wr_commit & hit_common)
                       ? merge(common_reg, pwdata_in[15:0], lane_mask & `COMMON_WRITE_MASK)
                       : common_reg;

    // ----------------------------------------------------------------
    // led condition decode
    // ----------------------------------------------------------------
    wire force_en   = ctrl_reg[`CTRL_FORCE_EN];
    wire [1:0] fsel = ctrl_reg[`CTRL_FORCE_HI:`CTRL_FORCE_LO];
    wire tx_recent  = tx_active_in | (tx_hold_reg != 5'd0);
    wire rx_recent  = rx_active_in | (rx_hold_reg != 5'd0);

    // steady conditions simply OR together
    wire steady_on  = link_up_in & (
                      (ctrl_reg[`CTRL_FDX_ON] & full_duplex_in)
                    | (ctrl_reg[`CTRL_HDX_ON] & !full_duplex_in)
                    | (ctrl_reg[`CTRL_TX_ON] & tx_recent)
                    | (ctrl_reg[`CTRL_RX_ON] & rx_recent)
                    | (ctrl_reg[`CTRL_FAST_ON] & speed_100_in)
                    | (ctrl_reg[`CTRL_SLOW_ON] & !speed_100_in));

    wire speed_duplex_on = ctrl_reg[`CTRL_FDX_ON] | ctrl_reg[`CTRL_HDX_ON]
                         | ctrl_reg[`CTRL_FAST_ON] | ctrl_reg[`CTRL_SLOW_ON];
    wire act_precond = ctrl_reg[`CTRL_FORCE_LO] | speed_duplex_on;
    // without override, traffic only blinks an led that would be lit
    wire act_allowed = ctrl_reg[`CTRL_ACT_OVERRIDE] | steady_on;
    wire act_blink   = link_up_in & act_precond & act_allowed & (
                       (ctrl_reg[`CTRL_TX_BLINK] & tx_active_in)
                     | (ctrl_reg[`CTRL_RX_BLINK] & rx_active_in));
    wire col_blink   = link_up_in & ctrl_reg[`CTRL_COL_BLINK] & collision_in;
    wire spd_blink   = link_up_in & (
                       (ctrl_reg[`CTRL_FAST_BLINK] & speed_100_in)
                     | (ctrl_reg[`CTRL_SLOW_BLINK] & !speed_100_in));
    wire any_blink   = act_blink | col_blink | spd_blink;
    wire blink_wave  = (act_blink | col_blink) ? wave_w[1] : wave_w[2];

    // force wins over everything, then blink, then steady
    always_comb begin
        case (led1_pkg::force_sel_t'(fsel))
            led1_pkg::FORCE_OFF:    led_next = 1'b0;
            led1_pkg::FORCE_ON:     led_next = 1'b1;
            led1_pkg::FORCE_BLINK1: led_next = wave_w[0];
            default:                led_next = wave_w[1];
        endcase
        if (!force_en) begin
            led_next = any_blink ? blink_wave : steady_on;
        end
    end

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    wire [15:0] status_w = {12'h000, force_en, steady_on, any_blink, led_reg};
    wire [15:0] rd_w     = hit_ctrl   ? ctrl_reg :
                           hit_blink  ? blink_reg :
                           hit_common ? common_reg :
                           hit_status ? status_w : 16'h0000;

    assign bus_state_next = (access & !pready_reg) ? led1_pkg::BUS_ANSWER : led1_pkg::BUS_IDLE;

    // ----------------------------------------------------------------
    // apb slave: one wait state, answer registered
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            bus_state_reg <= led1_pkg::BUS_IDLE;
            pready_reg    <= 1'b0;
            prdata_reg    <= 32'h0000_0000;
            pslverr_reg   <= 1'b0;
        end else begin
            bus_state_reg <= bus_state_next;
            pready_reg    <= (bus_state_next == led1_pkg::BUS_ANSWER);
            prdata_reg    <= (access & !pready_reg & !pwrite_in) ? {16'h0000, rd_w} : 32'h0000_0000;
            pslverr_reg   <= access & !pready_reg & !mapped;
        end
    end

    // register storage
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ctrl_reg   <= `LED_CTRL_RESET;
            blink_reg  <= `LED_BLINK_RESET;
            common_reg <= `LED_COMMON_RESET;
        end else begin
            ctrl_reg   <= ctrl_next;
            blink_reg  <= blink_next;
            common_reg <= common_next;
        end
    end

    // ----------------------------------------------------------------
    // millisecond tick and activity stretch
    // ----------------------------------------------------------------
    // hold loads one extra tick: the first tick may fall at once
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            tick_cnt_reg <= '0;
            ms_tick_reg  <= 1'b0;
        end else begin
            ms_tick_reg  <= (tick_cnt_reg == TICK_W'(MS_CYCLES - 1));
            tick_cnt_reg <= (tick_cnt_reg == TICK_W'(MS_CYCLES - 1)) ? '0 : tick_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            tx_hold_reg <= 5'd0;
            rx_hold_reg <= 5'd0;
        end else begin
            if (tx_active_in & link_up_in) begin
                tx_hold_reg <= HOLD_LOAD;
            end else if (ms_tick_reg & (tx_hold_reg != 5'd0)) begin
                tx_hold_reg <= tx_hold_reg - 5'd1;
            end
            if (rx_active_in & link_up_in) begin
                rx_hold_reg <= HOLD_LOAD;
            end else if (ms_tick_reg & (rx_hold_reg != 5'd0)) begin
                rx_hold_reg <= rx_hold_reg - 5'd1;
            end
        end
    end

    // ----------------------------------------------------------------
    // blink generators: mode 1, mode 2, mode 3
    // ----------------------------------------------------------------
    for (genvar g = 0; g < 3; g++) begin : g_blink
        blink_gen u_blink (
            .clk_in     (clk_in),
            .rst_n_in   (rst_n_in),
            .ms_tick_in (ms_tick_reg),
            .rate_in    (blink_reg[11-4*g -: 4]),
            .reverse_in (common_reg[`COMMON_REVERSE]),
            .wave_out   (wave_w[g])
        );
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            led_reg <= 1'b0;
        end else begin
            led_reg <= led_next;
        end
    end

    assign led_out     = led_reg;
    assign prdata_out  = prdata_reg;
    assign pready_out  = pready_reg;
    assign pslverr_out = pslverr_reg;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_force_off: assert property (
        (force_en && fsel == 2'b00) |=> !led_out)
        else $error("forced off but led lit");

    a_force_on: assert property (
        (force_en && fsel == 2'b01) |=> led_out)
        else $error("forced on but led dark");

    a_force_blink: assert property (
        (force_en && fsel == 2'b10) |=> (led_out == $past(wave_w[0])))
        else $error("forced blink not mode one");

    a_blink_first: assert property (
        (!force_en && any_blink) |=> (led_out == $past(blink_wave)))
        else $error("blink did not take precedence");

    a_fdx_steady: assert property (
        (!force_en && !any_blink && link_up_in && full_duplex_in
         && ctrl_reg[`CTRL_FDX_ON]) |=> led_out)
        else $error("full duplex led not on");

    a_idle_dark: assert property (
        (!force_en && !link_up_in) |=> !led_out)
        else $error("led lit with link down");

    a_tx_hold: assert property (
        (tx_active_in && link_up_in) ##1 !tx_active_in |-> (tx_hold_reg == HOLD_LOAD))
        else $error("activity hold not loaded");

    a_act_mode2: assert property (
        (!force_en && link_up_in && tx_active_in && ctrl_reg[`CTRL_TX_BLINK]
         && ctrl_reg[`CTRL_ACT_OVERRIDE] && speed_duplex_on) |=> (led_out == $past(wave_w[1])))
        else $error("tx blink not at mode two");

    a_rsvd_zero: assert property (
        (wr_commit && hit_ctrl) |=> (ctrl_reg[0] == 1'b0))
        else $error("reserved bit became set");

    a_ready_pulse: assert property (
        (access && !pready_reg) |=> pready_out ##1 !pready_out)
        else $error("pready not a single pulse");

    a_force_blink2: assert property (
        (force_en && fsel == 2'b11)
        |=> (led_out == $past(wave_w[1])))
        else $error("forced blink not mode two");

    a_hdx_steady: assert property (
        (!force_en && !any_blink && link_up_in
         && !full_duplex_in && ctrl_reg[`CTRL_HDX_ON])
        |=> led_out)
        else $error("half duplex led not on");

    a_fast_steady: assert property (
        (!force_en && !any_blink && link_up_in
         && speed_100_in && ctrl_reg[`CTRL_FAST_ON])
        |=> led_out)
        else $error("fast link led not on");

    a_slow_steady: assert property (
        (!force_en && !any_blink && link_up_in
         && !speed_100_in && ctrl_reg[`CTRL_SLOW_ON])
        |=> led_out)
        else $error("slow link led not on");

    a_col_blink: assert property (
        (!force_en && link_up_in && collision_in
         && ctrl_reg[`CTRL_COL_BLINK])
        |=> (led_out == $past(wave_w[1])))
        else $error("collision blink not at mode two");

    a_fast_blink: assert property (
        (!force_en && link_up_in && speed_100_in && ctrl_reg[`CTRL_FAST_BLINK]
         && !collision_in && !tx_active_in && !rx_active_in)
        |=> (led_out == $past(wave_w[2])))
        else $error("fast link blink not at mode three");

    a_slow_blink: assert property (
        (!force_en && link_up_in && !speed_100_in && ctrl_reg[`CTRL_SLOW_BLINK]
         && !collision_in && !tx_active_in && !rx_active_in)
        |=> (led_out == $past(wave_w[2])))
        else $error("slow link blink not at mode three");

    a_rx_hold: assert property (
        (rx_active_in && link_up_in) ##1 !rx_active_in
        |-> (rx_hold_reg == HOLD_LOAD))
        else $error("receive hold not loaded");

endmodule : led1_status_indicator

`default_nettype wire

// file: verilog/led1_map.svh
`ifndef LED1_MAP_SVH
`define LED1_MAP_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define LED_COMMON_IDX      16'h40c1
`define LED_BLINK_IDX       16'h40c2
`define LED_CTRL_IDX        16'h40c3
`define LED_STATUS_IDX      16'h40c4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LED_CTRL_RESET      16'h0310
`define LED_BLINK_RESET     16'hec75
`define LED_COMMON_RESET    16'h0000

// ----------------------------------------------------------------
// control and common register fields
// ----------------------------------------------------------------
`define CTRL_FORCE_EN       15
`define CTRL_FORCE_HI       14
`define CTRL_FORCE_LO       13
`define CTRL_ACT_OVERRIDE   12
`define CTRL_FDX_ON         11
`define CTRL_HDX_ON         10
`define CTRL_TX_BLINK       9
`define CTRL_RX_BLINK       8
`define CTRL_TX_ON          7
`define CTRL_RX_ON          6
`define CTRL_FAST_ON        5
`define CTRL_SLOW_ON        4
`define CTRL_COL_BLINK      3
`define CTRL_FAST_BLINK     2
`define CTRL_SLOW_BLINK     1
`define CTRL_WRITE_MASK     16'hfffe
`define COMMON_REVERSE      9
`define COMMON_WRITE_MASK   16'h0200

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define LED_CLK_HZ          250000000
`define LED_MS_CYCLES       (`LED_CLK_HZ / 1000)
`define ACT_HOLD_MS         10

`endif

// file: verilog/led1_pkg.sv
`default_nettype none

package led1_pkg;

    // apb slave answer state
    typedef enum logic [0:0] {
        BUS_IDLE   = 1'b0,
        BUS_ANSWER = 1'b1
    } bus_state_t;

    // force field encoding
    typedef enum logic [1:0] {
        FORCE_OFF    = 2'b00,
        FORCE_ON     = 2'b01,
        FORCE_BLINK1 = 2'b10,
        FORCE_BLINK2 = 2'b11
    } force_sel_t;

endpackage : led1_pkg

`default_nettype wire

// file: verilog/blink_gen.sv
`default_nettype none

module blink_gen (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       ms_tick_in,
    input  wire logic [3:0] rate_in,
    input  wire logic       reverse_in,
    output logic            wave_out
);

    // ----------------------------------------------------------------
    // rate table, in milliseconds
    // ----------------------------------------------------------------
    // shared by all blink modes; low codes blink rarely with a short off share
    function automatic logic [13:0] period_ms(input logic [3:0] code);
        case (code)
            4'h0:    period_ms = 14'd10000;
            4'h1:    period_ms = 14'd9400;
            4'h2:    period_ms = 14'd8000;
            4'h3:    period_ms = 14'd7400;
            4'h4:    period_ms = 14'd6000;
            4'h5:    period_ms = 14'd4000;
            4'h6:    period_ms = 14'd3000;
            4'h7:    period_ms = 14'd2000;
            4'h8:    period_ms = 14'd1500;
            4'h9:    period_ms = 14'd1000;
            4'ha:    period_ms = 14'd500;
            4'hb:    period_ms = 14'd333;
            4'hc:    period_ms = 14'd250;
            4'hd:    period_ms = 14'd167;
            4'he:    period_ms = 14'd125;
            default: period_ms = 14'd100;
        endcase
    endfunction : period_ms

    function automatic logic [13:0] off_ms(input logic [3:0] code);
        case (code)
            4'h0:    off_ms = 14'd600;
            4'h1:    off_ms = 14'd658;
            4'h2:    off_ms = 14'd640;
            4'h3:    off_ms = 14'd666;
            4'h4:    off_ms = 14'd660;
            4'h5:    off_ms = 14'd320;
            4'h6:    off_ms = 14'd330;
            4'h7:    off_ms = 14'd320;
            4'h8:    off_ms = 14'd240;
            4'h9:    off_ms = 14'd160;
            4'ha:    off_ms = 14'd250;
            4'hb:    off_ms = 14'd167;
            4'hc:    off_ms = 14'd125;
            4'hd:    off_ms = 14'd83;
            4'he:    off_ms = 14'd62;
            default: off_ms = 14'd50;
        endcase
    endfunction : off_ms

    logic [13:0] phase_reg;
    logic [13:0] phase_next;
    logic        wave_reg;
    wire  [13:0] period_w = period_ms(rate_in);
    wire         in_off_w = (phase_reg < off_ms(rate_in));
    // a rate change can leave the phase past the new period: wrap at once
    wire         wrap_w   = (phase_reg >= (period_w - 14'd1));

    assign phase_next = ms_tick_in ? (wrap_w ? 14'd0 : phase_reg + 14'd1) : phase_reg;
    assign wave_out   = wave_reg;

    // ----------------------------------------------------------------
    // phase counter and wave
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            phase_reg <= 14'd0;
            wave_reg  <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            wave_reg  <= reverse_in ? in_off_w : !in_off_w;
        end
    end

endmodule : blink_gen

`default_nettype wire

// file: bench/led_viewer.sv
`default_nettype none

// ----------------------------------------------------------------
// lamp model: counts lit cycles and level changes
// ----------------------------------------------------------------
module led_viewer (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        led_in,
    input  wire logic        clear_in,
    output logic [15:0]      lit_out,
    output logic [15:0]      edges_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic prev_reg;

    // a lamp has no timing of its own, so it only integrates what it sees
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || clear_in) begin
            lit_out   <= 16'h0000;
            edges_out <= 16'h0000;
        end else begin
            lit_out   <= lit_out + 16'(led_in);
            edges_out <= edges_out + 16'(led_in != prev_reg);
        end
        prev_reg <= led_in;
    end
endmodule : led_viewer

`default_nettype wire

// file: bench/testbench.sv
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    localparam int MS = 10;  // short millisecond keeps the run small
    logic        clk_in, rst_n_in, psel, penable, pwrite, pready, pslverr, err, led, clr;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [5:0]  stat;  // link, 100M, full duplex, tx, rx, collision
    logic [15:0] lit, edges, ctl;
    logic [21:0] tbl [8];
    int          n_fail, checked, cycles, seed, i;

    led1_status_indicator #(.MS_CYCLES(MS)) dut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .link_up_in(stat[5]), .speed_100_in(stat[4]), .full_duplex_in(stat[3]),
        .tx_active_in(stat[2]), .rx_active_in(stat[1]), .collision_in(stat[0]),
        .led_out(led)
    );

    led_viewer lamp (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .led_in(led), .clear_in(clr),
        .lit_out(lit), .edges_out(edges)
    );

    // ----------------------------------------------------------------
    // clock and hang guard
    // ----------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end

    // ceiling sits well above the roughly 57k cycles the sequence needs
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 80000) begin
            $display("[ERR] %0t run timed out", $time);
            n_fail++;
            finish_test();
        end
    end

    // ----------------------------------------------------------------
    // tasks and expectations
    // ----------------------------------------------------------------
    task automatic finish_test();
        $display("checked %0d failed %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
            n_fail++;
        end
    endtask : check

    // one apb transfer; waits for pready, only the run timeout ends a hang
    task automatic apb(input logic w, input logic [15:0] idx, input logic [15:0] wd);
        int n;
        @(posedge clk_in);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {14'h0000, idx, 2'b00};
        pwdata  <= {16'h0000, wd};
        @(posedge clk_in);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        check(32'(n), 32'h0000_0002, "bus answer"); // one wait state
    endtask : apb

    task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp, input logic e);
        apb(1'b0, idx, 16'h0000);
        check(rd, exp, "read data");
        check(32'(err), 32'(e), "slave error");
    endtask : rdchk

    task automatic drive(input logic [15:0] c, input logic [5:0] s);
        apb(1'b1, 16'h40c3, c);
        @(posedge clk_in);
        stat <= s;
    endtask : drive

    // clear the lamp counters, then let n cycles pass
    task automatic watch(input int n);
        @(posedge clk_in);
        clr <= 1'b1;
        @(posedge clk_in);
        clr <= 1'b0;
        repeat (n) @(posedge clk_in);
    endtask : watch

    function automatic logic exp_steady(input logic [15:0] c, input logic [5:0] s);
        return s[5] & ((c[11] & s[3]) | (c[10] & !s[3]) | (c[5] & s[4]) | (c[4] & !s[4]));
    endfunction : exp_steady

    function automatic logic exp_blink(input logic [15:0] c, input logic [5:0] s);
        return s[5] & ((c[3] & s[0]) | (c[2] & s[4]) | (c[1] & !s[4])
            | (((c[9] & s[2]) | (c[8] & s[1])) & (c[13] | (|{c[11:10], c[5:4]}))
               & (c[12] | exp_steady(c, s))));
    endfunction : exp_blink

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        seed = 97;
        n_fail = 0;
        checked = 0;
        cycles = 0;
        rst_n_in = 1'b0;
        {psel, penable, pwrite, clr} = 4'h0;
        {paddr, pwdata} = 64'h0000_0000_0000_0000;
        pstrb = 4'hf;
        stat = 6'h00;
        tbl = '{{16'h0004, 6'h30}, {16'h0002, 6'h20}, {16'h0008, 6'h21},
                {16'h1210, 6'h24}, {16'h0110, 6'h22}, {16'h3200, 6'h24},
                {16'h2200, 6'h24}, {16'h0004, 6'h10}};
        repeat (8) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rdchk(16'h40c3, 32'h0000_0310, 1'b0);
        rdchk(16'h40c2, 32'h0000_ec75, 1'b0);
        rdchk(16'h40c1, 32'h0000_0000, 1'b0);
        rdchk(16'h40c5, 32'h0000_0000, 1'b1);
        apb(1'b1, 16'h40c3, 16'hffff);
        rdchk(16'h40c3, 32'h0000_fffe, 1'b0);
        apb(1'b1, 16'h40c1, 16'hffff);
        rdchk(16'h40c1, 32'h0000_0200, 1'b0);
        apb(1'b1, 16'h40c1, 16'h0000);
        apb(1'b1, 16'h40c2, 16'hffff);
        // random steady-on mixes with random link state
        for (i = 0; i < 24; i++) begin
            ctl = 16'h0c30 & 16'($random(seed));
            drive(ctl, 6'h38 & 6'($random(seed)));
            repeat (3) @(posedge clk_in);
            check(32'(led), 32'(exp_steady(ctl, stat)), "steady led");
        end
        // force codes with every status condition true
        for (i = 0; i < 4; i++) begin
            drive(16'h8c3e | 16'(i << 13), 6'h3f);
            watch(3000);
            check(32'(i == 0 ? lit == 0 : i == 1 ? lit > 2900 : edges > 3), 1, "forced");
        end
        // blink conditions, including the ones that must stay quiet
        for (i = 0; i < 8; i++) begin
            drive(tbl[i][21:6], tbl[i][5:0]);
            watch(3000);
            check(32'(edges > 3), 32'(exp_blink(tbl[i][21:6], tbl[i][5:0])), "blink");
        end
        // single-cycle activity pulse must hold the lamp on
        for (i = 0; i < 2; i++) begin
            drive(i ? 16'h0040 : 16'h0080, 6'h20);
            @(posedge clk_in);
            stat <= i ? 6'h22 : 6'h24;
            @(posedge clk_in);
            stat <= 6'h20;
            watch(10 * MS);
            check(32'(lit), 32'(10 * MS - 1), "activity hold");
            repeat (30 * MS) @(posedge clk_in);
            check(32'(led), 32'h0000_0000, "hold expiry");
        end
        // slow code: long lit share, then the reversed duty
        apb(1'b1, 16'h40c2, 16'hfff9);
        drive(16'h0004, 6'h30);
        watch(1000 * MS);
        check(32'(lit > 16'd5000), 32'h0000_0001, "long lit share");
        apb(1'b1, 16'h40c1, 16'h0200);
        watch(1000 * MS);
        check(32'(lit < 16'd5000), 32'h0000_0001, "reversed share");
        finish_test();
    end
endmodule : testbench

`default_nettype wire
